//--- hw/telemetry_readback.sv
// How it works
// (RL1) Bit five low means corrections were made.
// (RL2) Correction bit refreshed on restore, reset, bulk read.
// (RL3) Info word read-only; other bits read zero.
// (RL4) Code 88h returns input voltage word.
// (RL5) Input voltage adds chip current times filter resistance.
// (RL6) Code 89h returns input current.
// (RL7) Code 8Bh returns paged output voltage.
// (RL8) Code 8Ch returns paged output current.
// (RL9) Code 8Dh returns paged external temperature.
// (RL10) Code 8Eh returns die temperature, affects nothing.
// (RL11) Code 95h returns paged switching frequency.
// (RL12) Code 96h returns output power from latest pair.
// (RL13) Code 97h returns input power from latest pair.
// (RL14) Code D7h holds paged output current peak.
// (RL15) Code D8h read/write select byte, resets zero.
// (RL16) Code DDh holds paged output voltage peak.
// (RL17) Code DEh holds input voltage peak.
// (RL18) Code DFh holds paged external temperature peak.
// (RL19) Code E1h holds input current peak.
// (RL20) Code E4h returns chip supply current.
// (RL21) Code F4h holds die temperature peak.
// (RL22) Other words use five-bit exponent, eleven-bit mantissa.
// (RL23) Zero select runs the round-robin loop.
// (RL24) Peaks keep the larger; clear reloads current.
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_regs.svh"

module telemetry_readback (
  input wire logic clk,
  input wire logic rst_b,
  input wire telemetry_pkg::cmd_s cmd,
  output telemetry_pkg::rsp_s rsp,
  input wire telemetry_pkg::meas_s meas,
  input wire logic [15:0] input_filter_resistance,
  input wire logic [4:0] vout_exponent,
  input wire logic peak_clear_command,
  input wire logic ecc_refresh,
  input wire logic ecc_corrected,
  output logic round_robin,
  output logic [7:0] fast_adc_select
);
  import telemetry_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------

  // Every flop of the block except the peak holders, registered as one word.
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] iin;
    logic [15:0] ichip;
    logic [15:0] die;
    logic [15:0] pin;
    logic [1:0][15:0] vout;
    logic [1:0][15:0] iout;
    logic [1:0][15:0] temp;
    logic [1:0][15:0] freq;
    logic [1:0][15:0] pout;
    logic [7:0] adc_sel;
    logic rr;
    logic ecc_ok;
    logic por_pend;
    rsp_s rsp;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Peak holder outputs, indexed by page where paged.
  logic [1:0][15:0] iout_pk;
  logic [1:0][15:0] vout_pk;
  logic [1:0][15:0] temp_pk;
  logic [15:0] vin_pk;
  logic [15:0] iin_pk;
  logic [15:0] die_pk;

  // Computed words offered to the state register; only vin_calc also feeds a peak holder.
  logic [15:0] vin_calc;
  logic [15:0] pin_calc;
  logic [15:0] pout_calc;

  // ----------------------------------------
  // Linear word arithmetic
  // ----------------------------------------

  // Pack a wide mantissa into the five/eleven word by shifting it down.
  // Low bits are dropped, which is the resolution the word offers anyway.
  function automatic logic [15:0] pack(input logic signed [47:0] m,
                                       input logic signed [7:0] e);
    logic signed [47:0] mm;
    logic signed [7:0] ee;
    mm = m;
    ee = e;
    for (int i = 0; i < 40; i++)
    begin
      if (mm > 48'sd1023 || mm < -48'sd1024)
      begin
        mm = mm >>> 1;
        ee = ee + 8'sd1;
      end
    end
    pack = {ee[4:0], mm[10:0]}; // [RL22]
  endfunction : pack

  // Mantissa of a five/eleven word, sign extended.
  function automatic logic signed [47:0] man(input logic [15:0] w);
    man = 48'(signed'(w[10:0]));
  endfunction : man

  // Exponent of a five/eleven word, sign extended.
  function automatic logic signed [7:0] expo(input logic [15:0] w);
    expo = 8'(signed'(w[15:11]));
  endfunction : expo

  // Product of two five/eleven words.
  function automatic logic [15:0] mul(input logic [15:0] a,
                                      input logic [15:0] b);
    mul = pack(man(a) * man(b), expo(a) + expo(b));
  endfunction : mul

  // Sum of two five/eleven words, aligned on the smaller exponent.
  // The shift is capped so a huge spread cannot overflow the mantissa.
  function automatic logic [15:0] add(input logic [15:0] a,
                                      input logic [15:0] b);
    logic signed [7:0] d;
    logic [4:0] sh;
    d = expo(a) - expo(b);
    if (d >= 0)
    begin
      sh = (d > 8'sd24) ? 5'd24 : d[4:0];
      add = pack((man(a) <<< sh) + man(b), expo(b));
    end
    else
    begin
      sh = (d < -8'sd24) ? 5'd24 : 5'(-d);
      add = pack(man(a) + (man(b) <<< sh), expo(a));
    end
  endfunction : add

  // ----------------------------------------
  // Derived values
  // ----------------------------------------

  // Filter drop compensation uses the chip current held so far.
  always_comb
  begin
    vin_calc = add(meas.word, mul(st_r.ichip, input_filter_resistance)); // [RL5]
  end

  // Input power pairs the newest voltage with the newest current.
  always_comb
  begin
    pin_calc = mul(st_r.vin, st_r.iin);
    if (meas.valid && meas.id == M_VIN_PIN)
    begin
      pin_calc = mul(vin_calc, st_r.iin); // [RL13]
    end
    else if (meas.valid && meas.id == M_IIN)
    begin
      pin_calc = mul(st_r.vin, meas.word); // [RL13]
    end
  end

  // Output power for the page just measured; voltage carries the mode exponent.
  always_comb
  begin
    logic [15:0] v;
    logic [15:0] i;
    v = st_r.vout[meas.page];
    i = st_r.iout[meas.page];
    if (meas.id == M_VOUT)
    begin
      v = meas.word;
    end
    if (meas.id == M_IOUT)
    begin
      i = meas.word;
    end
    pout_calc = pack(48'(signed'({1'b0, v})) * man(i), // [RL12]
                     8'(signed'(vout_exponent)) + expo(i));
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Readings, select byte, correction bit and the command answer.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    // A new reading lands in its slot and refreshes the matching power.
    if (meas.valid)
    begin
      unique case (meas.id)
        M_VIN_PIN:
        begin
          st_nxt.vin = vin_calc; // [RL5]
          st_nxt.pin = pin_calc;
        end
        M_IIN:
        begin
          st_nxt.iin = meas.word; // [RL6]
          st_nxt.pin = pin_calc;
        end
        M_ICHIP: st_nxt.ichip = meas.word; // [RL20]
        M_VOUT:
        begin
          st_nxt.vout[meas.page] = meas.word; // [RL7]
          st_nxt.pout[meas.page] = pout_calc; // [RL12]
        end
        M_IOUT:
        begin
          // Gain and temperature correction happen upstream of this word.
          st_nxt.iout[meas.page] = meas.word; // [RL8]
          st_nxt.pout[meas.page] = pout_calc;
        end
        M_TEMP_EXT: st_nxt.temp[meas.page] = meas.word; // [RL9]
        M_TEMP_DIE: st_nxt.die = meas.word; // [RL10]
        M_FREQ: st_nxt.freq[meas.page] = meas.word; // [RL11]
      endcase
    end
    // The correction flag is caught once after power-on, then on each refresh.
    if (st_r.por_pend || ecc_refresh)
    begin
      st_nxt.ecc_ok = !ecc_corrected; // [RL1] [RL2]
      st_nxt.por_pend = 1'b0;
    end
    // Serve one command per cycle; the answer follows one edge later.
    if (cmd.valid)
    begin
      st_nxt.rsp.valid = 1'b1;
      if (cmd.write)
      begin
        // Only the select byte takes writes; all else is read-only.
        if (cmd.code == `CMD_FAST_ADC)
        begin
          st_nxt.adc_sel = cmd.wdata; // [RL15]
        end
        else
        begin
          st_nxt.rsp.err = 1'b1; // [RL3]
        end
      end
      else
      begin
        unique case (cmd.code)
          `CMD_IN_VOLT: st_nxt.rsp.data = st_r.vin; // [RL4]
          `CMD_IN_CURR: st_nxt.rsp.data = st_r.iin; // [RL6]
          `CMD_OUT_VOLT: st_nxt.rsp.data = st_r.vout[cmd.page]; // [RL7]
          `CMD_OUT_CURR: st_nxt.rsp.data = st_r.iout[cmd.page]; // [RL8]
          `CMD_EXT_TEMP: st_nxt.rsp.data = st_r.temp[cmd.page]; // [RL9]
          `CMD_DIE_TEMP: st_nxt.rsp.data = st_r.die; // [RL10]
          `CMD_FREQ: st_nxt.rsp.data = st_r.freq[cmd.page]; // [RL11]
          `CMD_OUT_PWR: st_nxt.rsp.data = st_r.pout[cmd.page]; // [RL12]
          `CMD_IN_PWR: st_nxt.rsp.data = st_r.pin; // [RL13]
          `CMD_OUT_CURR_PK: st_nxt.rsp.data = iout_pk[cmd.page]; // [RL14]
          `CMD_FAST_ADC: st_nxt.rsp.data = {8'h00, st_r.adc_sel}; // [RL15]
          `CMD_OUT_VOLT_PK: st_nxt.rsp.data = vout_pk[cmd.page]; // [RL16]
          `CMD_IN_VOLT_PK: st_nxt.rsp.data = vin_pk; // [RL17]
          `CMD_EXT_TEMP_PK: st_nxt.rsp.data = temp_pk[cmd.page]; // [RL18]
          `CMD_IN_CURR_PK: st_nxt.rsp.data = iin_pk; // [RL19]
          `CMD_CHIP_CURR: st_nxt.rsp.data = st_r.ichip; // [RL20]
          `CMD_DIE_TEMP_PK: st_nxt.rsp.data = die_pk; // [RL21]
          `CMD_EEPROM_INFO:
          begin
            st_nxt.rsp.data = 16'h0000; // [RL3]
            st_nxt.rsp.data[`ECC_BIT_POS] = st_r.ecc_ok; // [RL1]
          end
          default: st_nxt.rsp.err = 1'b1;
        endcase
      end
    end
    // Round robin runs whenever the select byte is zero.
    st_nxt.rr = (st_nxt.adc_sel == 8'h00); // [RL23]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Readings start at zero until the first conversion lands.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
      st_r.adc_sel <= `FAST_ADC_RST; // [RL15]
      st_r.rr <= 1'b1;
      st_r.ecc_ok <= 1'b1;
      st_r.por_pend <= 1'b1; // [RL2]
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Peak holders
  // ----------------------------------------

  // Paged holders, one set per output channel.
  for (genvar p = 0; p < `NUM_PAGES; p++)
  begin : g_page
    logic hit;
    assign hit = meas.valid && (meas.page == 1'(p));

    // Output current peak.
    peak_hold #(.UNSIGNED16(1'b0)) u_iout (
      .clk(clk),
      .rst_b(rst_b),
      .clear(peak_clear_command),
      .upd(hit && meas.id == M_IOUT), // [RL14]
      .value(meas.word),
      .cur(st_r.iout[p]),
      .peak(iout_pk[p])
    );

    // Output voltage peak, unsigned sixteen-bit words.
    peak_hold #(.UNSIGNED16(1'b1)) u_vout (
      .clk(clk),
      .rst_b(rst_b),
      .clear(peak_clear_command),
      .upd(hit && meas.id == M_VOUT), // [RL16]
      .value(meas.word),
      .cur(st_r.vout[p]),
      .peak(vout_pk[p])
    );

    // External temperature peak.
    peak_hold #(.UNSIGNED16(1'b0)) u_temp (
      .clk(clk),
      .rst_b(rst_b),
      .clear(peak_clear_command),
      .upd(hit && meas.id == M_TEMP_EXT), // [RL18]
      .value(meas.word),
      .cur(st_r.temp[p]),
      .peak(temp_pk[p])
    );
  end

  // Input voltage peak follows the compensated value.
  peak_hold #(.UNSIGNED16(1'b0)) u_vin (
    .clk(clk),
    .rst_b(rst_b),
    .clear(peak_clear_command),
    .upd(meas.valid && meas.id == M_VIN_PIN), // [RL17]
    .value(vin_calc),
    .cur(st_r.vin),
    .peak(vin_pk)
  );

  // Input current peak.
  peak_hold #(.UNSIGNED16(1'b0)) u_iin (
    .clk(clk),
    .rst_b(rst_b),
    .clear(peak_clear_command),
    .upd(meas.valid && meas.id == M_IIN), // [RL19]
    .value(meas.word),
    .cur(st_r.iin),
    .peak(iin_pk)
  );

  // Die temperature peak.
  peak_hold #(.UNSIGNED16(1'b0)) u_die (
    .clk(clk),
    .rst_b(rst_b),
    .clear(peak_clear_command),
    .upd(meas.valid && meas.id == M_TEMP_DIE), // [RL21]
    .value(meas.word),
    .cur(st_r.die),
    .peak(die_pk)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // All outputs come straight from the state register.
  assign rsp = st_r.rsp;
  assign round_robin = st_r.rr; // [RL23]
  assign fast_adc_select = st_r.adc_sel;

endmodule : telemetry_readback

`default_nettype wire

//--- hw/telemetry_regs.svh
`ifndef TELEMETRY_REGS_SVH
`define TELEMETRY_REGS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_IN_VOLT 8'h88
`define CMD_IN_CURR 8'h89
`define CMD_OUT_VOLT 8'h8B
`define CMD_OUT_CURR 8'h8C
`define CMD_EXT_TEMP 8'h8D
`define CMD_DIE_TEMP 8'h8E
`define CMD_FREQ 8'h95
`define CMD_OUT_PWR 8'h96
`define CMD_IN_PWR 8'h97
`define CMD_OUT_CURR_PK 8'hD7
`define CMD_FAST_ADC 8'hD8
`define CMD_OUT_VOLT_PK 8'hDD
`define CMD_IN_VOLT_PK 8'hDE
`define CMD_EXT_TEMP_PK 8'hDF
`define CMD_IN_CURR_PK 8'hE1
`define CMD_CHIP_CURR 8'hE4
`define CMD_DIE_TEMP_PK 8'hF4
`define CMD_EEPROM_INFO 8'hB6

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ECC_BIT_POS 5
`define FAST_ADC_RST 8'h00
`define WORD_RST 16'h0000
`define NUM_PAGES 2

`endif

//--- hw/telemetry_pkg.sv
// ----------------------------------------
// Shared types
// ----------------------------------------
package telemetry_pkg;

  // Source of one new reading from the measurement path.
  typedef enum logic [2:0] {
    M_VIN_PIN = 3'b000,
    M_IIN = 3'b001,
    M_ICHIP = 3'b010,
    M_VOUT = 3'b011,
    M_IOUT = 3'b100,
    M_TEMP_EXT = 3'b101,
    M_TEMP_DIE = 3'b110,
    M_FREQ = 3'b111
  } meas_id_e;

  // One command from the serial engine.
  typedef struct packed {
    logic valid;
    logic write;
    logic page;
    logic [7:0] code;
    logic [7:0] wdata;
  } cmd_s;

  // Registered answer to a command.
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } rsp_s;

  // One new reading, already in its word format.
  typedef struct packed {
    logic valid;
    meas_id_e id;
    logic page;
    logic [15:0] word;
  } meas_s;

endpackage : telemetry_pkg

//--- hw/peak_hold.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Peak holder for one linear word
// ----------------------------------------
module peak_hold #(
  parameter bit UNSIGNED16 = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic upd,
  input wire logic [15:0] value,
  input wire logic [15:0] cur,
  output logic [15:0] peak
);
  import telemetry_pkg::*;

  // Whole state of the holder.
  typedef struct packed {
    logic [15:0] peak;
  } ph_s;

  ph_s st_r;
  ph_s st_nxt;

  // Decode to a common fixed point so words with different exponents compare.
  function automatic logic signed [63:0] fix(input logic [15:0] w);
    logic signed [63:0] m;
    logic [5:0] sh;
    m = 64'(signed'(w[10:0]));
    sh = 6'(signed'(w[15:11]) + 16);
    fix = m <<< sh;
  endfunction : fix

  // Keep the larger; a clear reloads the present reading, a new reading wins.
  always_comb
  begin
    st_nxt = st_r;
    if (clear)
    begin
      st_nxt.peak = upd ? value : cur; // [RL24]
    end
    else if (upd)
    begin
      // Output voltage is unsigned with one shared exponent.
      if (UNSIGNED16 ? (value > st_r.peak) : (fix(value) > fix(st_r.peak)))
      begin
        st_nxt.peak = value; // [RL24]
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign peak = st_r.peak;

endmodule : peak_hold

`default_nettype wire

//--- dv/telemetry_readback_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_regs.svh"

// ----------------------------------------
// Port checker for the read-back block
// ----------------------------------------
module telemetry_readback_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire telemetry_pkg::cmd_s cmd,
  input wire telemetry_pkg::rsp_s rsp,
  input wire telemetry_pkg::meas_s meas,
  input wire logic peak_clear_command,
  input wire logic ecc_refresh,
  input wire logic ecc_corrected,
  input wire logic round_robin,
  input wire logic [7:0] fast_adc_select
);
  import telemetry_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // A select write is the only event allowed to move the select byte.
  wire sel_wr = cmd.valid && cmd.write && (cmd.code == `CMD_FAST_ADC);
  // Reads of the info word and of the output current word.
  wire info_rd = cmd.valid && !cmd.write && (cmd.code == `CMD_EEPROM_INFO);
  wire iout_rd = cmd.valid && !cmd.write && (cmd.code == `CMD_OUT_CURR);

  a_rsp_latency: assert property (cmd.valid |=> rsp.valid)
    else $error("answer missing one cycle after a command");
  a_rsp_idle: assert property (!cmd.valid |=> !rsp.valid)
    else $error("answer without a command");
  a_sel_write: assert property (sel_wr |=>
    fast_adc_select == $past(cmd.wdata) && !rsp.err)
    else $error("select byte did not take the written value");
  a_sel_hold: assert property (!sel_wr |=> $stable(fast_adc_select))
    else $error("select byte moved without a write");
  a_rr_level: assert property (round_robin == (fast_adc_select == 8'h00))
    else $error("round robin flag disagrees with select byte");
  a_ro_refuse: assert property (cmd.valid && cmd.write && !sel_wr
    |=> rsp.err && rsp.data == 16'h0000)
    else $error("write to a read-only code was not refused");
  a_info_rsvd: assert property (info_rd |=> !rsp.err && (rsp.data & 16'hFFDF) == 16'h0000)
    else $error("reserved info bits not zero");
  a_ecc_refresh: assert property (ecc_refresh ##1 !ecc_refresh
    ##1 (info_rd && !ecc_refresh) |=> rsp.data[5] == !$past(ecc_corrected, 3))
    else $error("correction bit not refreshed");
  a_iout_store: assert property (meas.valid && meas.id == M_IOUT ##1 !meas.valid
    ##1 (iout_rd && cmd.page == $past(meas.page, 2) && !meas.valid)
    |=> rsp.data == $past(meas.word, 3))
    else $error("output current read did not return the stored reading");

  c_sel_write: cover property (sel_wr ##1 rsp.valid);
  c_ecc_read: cover property (ecc_refresh ##2 info_rd);
  c_peak_clear: cover property (peak_clear_command ##2 cmd.valid);
endmodule : telemetry_readback_checker

bind telemetry_readback telemetry_readback_checker u_chk (.clk, .rst_b, .cmd, .rsp, .meas,
  .peak_clear_command, .ecc_refresh, .ecc_corrected, .round_robin, .fast_adc_select);

`default_nettype wire

//--- dv/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Serial host side, one command per call
// ----------------------------------------
module pmbus_host_model (
  input wire logic clk,
  output telemetry_pkg::cmd_s cmd
);
  import telemetry_pkg::*;

  // Idle bus at time zero.
  initial cmd = '0;

  // Raised after a falling edge, held over one rising edge, then scrambled so
  // that a stale value can never pass for a fresh one.
  task automatic send(input logic wr, input logic pg, input logic [7:0] code,
                      input logic [7:0] wd);
    begin
      @(negedge clk);
      cmd <= '{valid: 1'b1, write: wr, page: pg, code: code, wdata: wd};
      @(negedge clk);
      cmd <= '{valid: 1'b0, write: ~wr, page: ~pg, code: ~code, wdata: ~wd};
    end
  endtask : send
endmodule : pmbus_host_model

`default_nettype wire

//--- dv/tb_telemetry_readback.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_telemetry_readback;
  import telemetry_pkg::*;

  // One expected answer; mask selects the data bits that are compared.
  typedef struct packed {logic err; logic [15:0] data; logic [15:0] mask;} note_s;
  localparam meas_id_e IDS [7] = '{M_IIN, M_ICHIP, M_VOUT, M_IOUT, M_TEMP_EXT, M_TEMP_DIE, M_FREQ};
  localparam logic [7:0] RCODE [7] = '{8'h89, 8'hE4, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h95};
  localparam logic [7:0] PCODE [7] = '{8'hE1, 8'h00, 8'hDD, 8'hD7, 8'hDF, 8'hF4, 8'h00};
  localparam bit PAGED [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  cmd_s cmd;
  rsp_s rsp;
  meas_s meas = '0;
  logic [15:0] input_filter_resistance = 16'h0000;
  logic [4:0] vout_exponent = 5'h00;
  logic peak_clear_command = 1'b0;
  logic ecc_refresh = 1'b0;
  logic ecc_corrected = 1'b0;
  logic round_robin;
  logic [7:0] fast_adc_select;
  note_s notes[$];
  int error_cnt = 0;
  int check_count = 0;

  // 40 MHz clock.
  always #12.5 clk = ~clk;

  pmbus_host_model host (.clk, .cmd);
  telemetry_readback uut (.clk, .rst_b, .cmd, .rsp, .meas, .input_filter_resistance,
    .vout_exponent, .peak_clear_command, .ecc_refresh, .ecc_corrected, .round_robin,
    .fast_adc_select);

  // Single comparison point.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask : chk

  // Note the answer first, then let the host issue the command.
  task automatic op(input logic wr, input logic pg, input logic [7:0] code,
    input logic [7:0] wd, input logic err, input logic [15:0] exp, input logic [15:0] mask);
    begin
      notes.push_back('{err, exp, mask});
      host.send(wr, pg, code, wd);
    end
  endtask : op

  // One-cycle measurement pulse.
  task automatic put(input meas_id_e mid, input logic pg, input logic [15:0] w);
    begin
      @(negedge clk);
      meas <= '{valid: 1'b1, id: mid, page: pg, word: w};
      @(negedge clk);
      meas.valid <= 1'b0;
    end
  endtask : put

  // Answers stand one cycle, so the falling edge always sees them settled.
  always @(negedge clk)
  begin
    if (rsp.valid === 1'b1)
    begin
      if (notes.size() == 0)
        chk({15'h0000, rsp.valid}, 16'h0000);
      else
      begin
        chk({15'h0000, rsp.err}, {15'h0000, notes[0].err});
        chk(rsp.data & notes[0].mask, notes[0].data & notes[0].mask);
        void'(notes.pop_front());
      end
    end
  end

  task automatic summarize();
    begin
      $display("checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : summarize

  // Main sequence.
  initial
  begin
    logic p;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [7:0] b;
    void'($urandom(32'hf8b418a5));
    input_filter_resistance = 16'($urandom);
    vout_exponent = 5'($urandom);
    repeat (3) @(negedge clk);
    rst_b <= 1'b1;
    op(1'b0, 1'b0, 8'hD8, 8'h00, 1'b0, 16'h0000, 16'hFFFF);
    op(1'b0, 1'b0, 8'hB6, 8'h00, 1'b0, 16'h0020, 16'hFFFF);
    chk({15'h0000, round_robin}, 16'h0001);
    $display("test reset done");
    b = 8'($urandom_range(255, 1));
    op(1'b1, 1'b0, 8'hD8, b, 1'b0, 16'h0000, 16'hFFFF);
    op(1'b0, 1'b0, 8'hD8, 8'h00, 1'b0, {8'h00, b}, 16'hFFFF);
    chk({8'h00, fast_adc_select}, {8'h00, b});
    chk({15'h0000, round_robin}, 16'h0000);
    op(1'b1, 1'b0, 8'hD8, 8'h00, 1'b0, 16'h0000, 16'hFFFF);
    chk({15'h0000, round_robin}, 16'h0001);
    op(1'b1, 1'b0, 8'h8C, b, 1'b1, 16'h0000, 16'hFFFF);
    op(1'b0, 1'b0, 8'h90, 8'h00, 1'b1, 16'h0000, 16'hFFFF);
    $display("test select done");
    // Small positive words share exponent zero, so hi is the larger in any reading.
    for (int i = 0; i < 7; i++)
    begin
      p = 1'($urandom);
      lo = {7'h00, 9'($urandom)};
      hi = lo | 16'h0200;
      put(IDS[i], p, hi);
      put(IDS[i], p, lo);
      op(1'b0, p, RCODE[i], 8'h00, 1'b0, lo, 16'hFFFF);
      if (PCODE[i] != 8'h00)
      begin
        op(1'b0, p, PCODE[i], 8'h00, 1'b0, hi, 16'hFFFF);
        @(negedge clk);
        peak_clear_command <= 1'b1;
        @(negedge clk);
        peak_clear_command <= 1'b0;
        op(1'b0, p, PCODE[i], 8'h00, 1'b0, lo, 16'hFFFF);
      end
      if (PAGED[i])
      begin
        put(IDS[i], ~p, hi);
        op(1'b0, p, RCODE[i], 8'h00, 1'b0, lo, 16'hFFFF);
      end
    end
    // Small exact words keep every sum and product inside one mantissa.
    b = 8'($urandom);
    input_filter_resistance <= 16'h0002;
    put(M_ICHIP, 1'b0, 16'h0003);
    put(M_IIN, 1'b0, 16'h0002);
    put(M_VIN_PIN, 1'b0, {8'h00, b});
    lo = {8'h00, b} + 16'h0006;
    op(1'b0, 1'b0, 8'h88, 8'h00, 1'b0, lo, 16'hFFFF);
    op(1'b0, 1'b0, 8'hDE, 8'h00, 1'b0, lo, 16'hFFFF);
    op(1'b0, 1'b0, 8'h97, 8'h00, 1'b0, lo << 1, 16'hFFFF);
    put(M_VOUT, p, 16'h0003);
    put(M_IOUT, p, 16'h0002);
    op(1'b0, p, 8'h96, 8'h00, 1'b0, {vout_exponent, 11'h006}, 16'hFFFF);
    $display("test readings done");
    ecc_corrected <= 1'b1;
    op(1'b0, 1'b0, 8'hB6, 8'h00, 1'b0, 16'h0020, 16'hFFFF);
    @(negedge clk);
    ecc_refresh <= 1'b1;
    @(negedge clk);
    ecc_refresh <= 1'b0;
    op(1'b0, 1'b0, 8'hB6, 8'h00, 1'b0, 16'h0000, 16'hFFFF);
    $display("test correction bit done");
    for (int k = 0; k < 20 && notes.size() != 0; k++)
      @(negedge clk);
    chk(16'(notes.size()), 16'h0000);
    summarize();
  end
endmodule : tb_telemetry_readback

`default_nettype wire
